/* src/escf_pkg.sv */
package escf_pkg;
   // operation classes issued by decode
   typedef enum logic [3:0] {
      OP_BRK_REG, OP_BRK_LIT, OP_SHIFT_REG, OP_SHIFT_LIT, OP_CMP,
      OP_FADD, OP_FRSUB, OP_FMUL, OP_FDIV, OP_PREFIX
   } escf_op_e;

   // latencies in processor cycles, issue edge to result
   localparam logic [4:0] LAT_BRK    = 5'h03;
   localparam logic [4:0] LAT_SHIFT  = 5'h02;
   localparam logic [4:0] LAT_CMP    = 5'h01;
   localparam logic [4:0] LAT_FADD   = 5'h06;
   localparam logic [4:0] LAT_FMUL   = 5'h06;
   localparam logic [4:0] LAT_FDIV   = 5'h1e;
   localparam logic [4:0] LAT_PREFIX = 5'h01;

   // float constants
   localparam logic [31:0] QNAN_PAT  = 32'hffc00000;
   localparam logic [4:0]  CAUSE_FP  = 5'h06;
   localparam logic [7:0]  EXP_MAX   = 8'hff;
   localparam logic [9:0]  EXP_BIAS  = 10'h07f;
   localparam logic [7:0]  ALIGN_MAX = 8'h1b;

   // register map (byte addresses) and field positions
   localparam int unsigned ADDR_W      = 4;
   localparam logic [3:0]  ADDR_MSTATE = 4'h0;
   localparam logic [3:0]  ADDR_FSTAT  = 4'h4;
   localparam logic [3:0]  ADDR_ESTAT  = 4'h8;
   localparam logic [3:0]  ADDR_CTRL   = 4'hc;
   localparam int unsigned MS_BRK_BIT  = 0;
   localparam int unsigned CTRL_BSH_BIT = 0;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // one decoded instruction with its operands
   typedef struct packed {
      escf_op_e    op;
      logic        leftDir;
      logic        signFillSel;
      logic        noSignFlag;
      logic [31:0] firstSrc;
      logic [31:0] secondSrc;
      logic [15:0] literalField;
      logic [31:0] pc;
   } escf_issue_s;

   // float status flags, denorm in bit 0
   typedef struct packed {
      logic divZero;
      logic overflow;
      logic underflow;
      logic invalidOp;
      logic denormOp;
   } escf_fflags_s;

   typedef struct packed {
      logic [31:0]  val;
      escf_fflags_s fl;
   } escf_fres_s;

   // completed result waiting for its final cycle
   typedef struct packed {
      logic         wr;
      logic         pcLd;
      logic         exc;
      escf_fflags_s fl;
      logic [31:0]  data;
      logic [31:0]  target;
   } escf_res_s;
endpackage : escf_pkg

/* src/escf_exec.sv */
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - break reg: save pc, jump second_src, 3 cycles
// - break literal: save pc, jump sign-extended literal
// - shift first_src by low five bits
// - direction bit set shifts left, else right
// - sign select gives arithmetic right shift, else zero
// - immediate shift amount from literal, prefix ignored
// - shifts take 2 cycles; result written only when enabled
// - compare computes second minus first, 1 cycle
// - msb replaced by first greater than second
// - unsigned flag selects unsigned msb relation
// - denormal operand gives nan, denorm flag, cause
// - add invalid cases give nan; 6 cycles
// - reverse subtract, like infinities are invalid
// - multiply invalid on signaling nan, zero*inf
// - divide 30 cycles; 0/0, inf/inf invalid
// - zero divisor gives signed infinity, divide flag
// - quiet nan input returns nan, no flags
// - denormal result gives signed zero, underflow
// - overflowing result gives signed infinity, overflow
// - float exception leaves destination unchanged
// - multiply writes product when no exception
// - prefix holds upper literal for next instruction
module escf_exec
   import escf_pkg::*;
#(
   parameter logic BARREL_EN_RST = 1'b1  // barrel shifter option at reset
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   // decode side
   input  wire logic              issueValid,
   output logic                   issueReady,
   input  wire escf_issue_s       issue,
   // writeback and exception side
   output logic                   wbValid,
   output logic [31:0]            wbData,
   output logic                   pcLoad,
   output logic [31:0]            pcTarget,
   output logic                   excReq,
   output logic                   breakActive,
   output escf_fflags_s           floatStatus,
   output logic [4:0]             causeCode,
   // register bus
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   // operand classification
   function automatic logic fIsInf(input logic [31:0] x);
      return x[30:0] == {EXP_MAX, 23'h0};
   endfunction : fIsInf
   function automatic logic fIsNan(input logic [31:0] x);
      return (x[30:23] == EXP_MAX) && (x[22:0] != 23'h0);
   endfunction : fIsNan
   function automatic logic fIsSnan(input logic [31:0] x);
      return fIsNan(x) && !x[22];
   endfunction : fIsSnan
   function automatic logic fIsDnz(input logic [31:0] x);
      return (x[30:23] == 8'h00) && (x[22:0] != 23'h0);
   endfunction : fIsDnz
   function automatic logic fIsZero(input logic [31:0] x);
      return x[30:0] == 31'h0;
   endfunction : fIsZero

   // float add, reverse subtract, multiply, divide; a is first, b second.
   // mantissas truncate; no rounding, which keeps the datapath small
   function automatic escf_fres_s fpCalc(input escf_op_e op,
                                         input logic [31:0] a,
                                         input logic [31:0] b);
      escf_fres_s         r;
      logic [31:0]        p;
      logic [31:0]        q;
      logic [31:0]        t;
      logic               inv;
      logic               sgn;
      logic               infR;
      logic               zeroR;
      logic signed [10:0] e;
      logic [27:0]        mb;
      logic [27:0]        ms;
      logic [27:0]        sum;
      logic [47:0]        prod;
      logic [48:0]        quo;
      logic [23:0]        m;
      logic [7:0]         d;
      r = '0; p = a; q = b; t = '0; sgn = 1'b0; infR = 1'b0; zeroR = 1'b0;
      e = '0; mb = '0; ms = '0; sum = '0; prod = '0; quo = '0; m = '0; d = '0;
      case (op)
         OP_FADD:  inv = fIsInf(a) && fIsInf(b) && (a[31] != b[31]);
         OP_FRSUB: inv = fIsInf(a) && fIsInf(b) && (a[31] == b[31]);
         OP_FMUL:  inv = (fIsZero(a) && fIsInf(b)) || (fIsZero(b) && fIsInf(a));
         OP_FDIV:  inv = (fIsZero(a) && fIsZero(b)) || (fIsInf(a) && fIsInf(b));
         default:  inv = 1'b0;
      endcase
      if (fIsDnz(a) || fIsDnz(b)) begin
         r.val = QNAN_PAT;
         r.fl.denormOp = 1'b1;
      end else if (fIsSnan(a) || fIsSnan(b) || inv) begin
         r.val = QNAN_PAT;
         r.fl.invalidOp = 1'b1;
      end else if (fIsNan(a) || fIsNan(b)) begin
         r.val = QNAN_PAT;
      end else if (op == OP_FDIV && fIsZero(a) && !fIsInf(b)) begin
         r.val = {a[31] ^ b[31], EXP_MAX, 23'h0};
         r.fl.divZero = 1'b1;
      end else begin
         if (op == OP_FMUL || op == OP_FDIV) begin
            sgn = a[31] ^ b[31];
            if (fIsInf(b) || (op == OP_FMUL && fIsInf(a))) begin
               infR = 1'b1;
            end else if (fIsZero(b) || fIsInf(a) || fIsZero(a)) begin
               zeroR = 1'b1;
            end else if (op == OP_FMUL) begin
               prod = {1'b1, a[22:0]} * {1'b1, b[22:0]};
               e = $signed({3'h0, a[30:23]}) + $signed({3'h0, b[30:23]})
                   - $signed({1'b0, EXP_BIAS});
               if (prod[47]) begin
                  m = prod[47:24];
                  e = e + 11'sd1;
               end else begin
                  m = prod[46:23];
               end
            end else begin
               quo = {1'b1, b[22:0], 25'h0} / {25'h0, 1'b1, a[22:0]};
               e = $signed({3'h0, b[30:23]}) - $signed({3'h0, a[30:23]})
                   + $signed({1'b0, EXP_BIAS});
               if (quo[25]) begin
                  m = quo[25:2];
               end else begin
                  m = quo[24:1];
                  e = e - 11'sd1;
               end
            end
         end else begin
            // reverse subtract is second plus negated first
            if (op == OP_FRSUB) p = {~a[31], a[30:0]};
            if (fIsInf(p) || fIsInf(q)) begin
               infR = 1'b1;
               sgn  = fIsInf(p) ? p[31] : q[31];
            end else begin
               if (p[30:0] < q[30:0]) begin
                  t = p;
                  p = q;
                  q = t;
               end
               sgn = p[31];
               mb  = {1'b0, |p[30:23], p[22:0], 3'h0};
               ms  = {1'b0, |q[30:23], q[22:0], 3'h0};
               d   = p[30:23] - q[30:23];
               ms  = (d > ALIGN_MAX) ? 28'h0 : (ms >> d);
               sum = (p[31] == q[31]) ? (mb + ms) : (mb - ms);
               e   = $signed({3'h0, p[30:23]});
               if (sum == 28'h0) begin
                  zeroR = 1'b1;
                  sgn   = 1'b0;
               end else if (sum[27]) begin
                  sum = sum >> 1;
                  e   = e + 11'sd1;
               end else begin
                  for (int i = 0; i < 26; i++) begin
                     if (!sum[26]) begin
                        sum = sum << 1;
                        e   = e - 11'sd1;
                     end
                  end
               end
               m = sum[26:3];
            end
         end
         if (infR) begin
            r.val = {sgn, EXP_MAX, 23'h0};
         end else if (zeroR) begin
            r.val = {sgn, 31'h0};
         end else if (e >= $signed({3'h0, EXP_MAX})) begin
            r.val = {sgn, EXP_MAX, 23'h0};
            r.fl.overflow = 1'b1;
         end else if (e <= 11'sd0) begin
            r.val = {sgn, 31'h0};
            r.fl.underflow = 1'b1;
         end else begin
            r.val = {sgn, e[7:0], m[22:0]};
         end
      end
      return r;
   endfunction : fpCalc

   // latency lookup per operation
   function automatic logic [4:0] latOf(input escf_op_e op);
      case (op)
         OP_BRK_REG, OP_BRK_LIT:     return LAT_BRK;
         OP_SHIFT_REG, OP_SHIFT_LIT: return LAT_SHIFT;
         OP_CMP:                     return LAT_CMP;
         OP_FADD, OP_FRSUB:          return LAT_FADD;
         OP_FMUL:                    return LAT_FMUL;
         OP_FDIV:                    return LAT_FDIV;
         default:                    return LAT_PREFIX;
      endcase
   endfunction : latOf

   logic [4:0]  cntFf;       // cycles left for the instruction in flight
   escf_res_s   pendFf;      // result held until its last cycle
   escf_res_s   nowRes;      // result of the instruction being issued
   escf_fres_s  fres;        // float unit output
   logic        immValidFf;  // upper literal held for the next instruction
   logic [15:0] immHiFf;
   logic        barrelEnFf;  // shifter option enable, software set
   logic        take;
   logic        fire;        // final cycle of an instruction
   escf_res_s   fin;
   logic [4:0]  shAmt;
   logic [31:0] diff;

   assign issueReady = (cntFf == 5'h0);
   assign take       = issueValid && issueReady;
   assign fire       = (take && latOf(issue.op) == 5'h1) || (cntFf == 5'h1);
   assign fin        = (cntFf == 5'h1) ? pendFf : nowRes;

   // result of the instruction being issued, computed at its issue edge
   always_comb begin
      nowRes = '0;
      fres   = fpCalc(issue.op, issue.firstSrc, issue.secondSrc);
      shAmt  = (issue.op == OP_SHIFT_REG) ? issue.secondSrc[4:0]
                                          : issue.literalField[4:0];
      diff   = issue.secondSrc + ~issue.firstSrc + 32'h1;
      case (issue.op)
         OP_BRK_REG, OP_BRK_LIT: begin
            nowRes.wr     = 1'b1;
            nowRes.pcLd   = 1'b1;
            nowRes.data   = issue.pc;
            if (issue.op == OP_BRK_REG) nowRes.target = issue.secondSrc;
            else if (immValidFf) nowRes.target = {immHiFf, issue.literalField};
            else nowRes.target = {{16{issue.literalField[15]}}, issue.literalField};
         end
         OP_SHIFT_REG, OP_SHIFT_LIT: begin
            nowRes.wr = barrelEnFf;
            if (issue.leftDir) nowRes.data = issue.firstSrc << shAmt;
            else if (issue.signFillSel)
               nowRes.data = $unsigned($signed(issue.firstSrc) >>> shAmt);
            else nowRes.data = issue.firstSrc >> shAmt;
         end
         OP_CMP: begin
            nowRes.wr   = 1'b1;
            nowRes.data = diff;
            nowRes.data[31] = issue.noSignFlag
               ? (issue.firstSrc > issue.secondSrc)
               : ($signed(issue.firstSrc) > $signed(issue.secondSrc));
         end
         OP_FADD, OP_FRSUB, OP_FMUL, OP_FDIV: begin
            nowRes.fl   = fres.fl;
            nowRes.exc  = |fres.fl;
            nowRes.wr   = ~|fres.fl;
            nowRes.data = fres.val;
         end
         default: nowRes = '0;
      endcase
   end

   // latency counter and held result
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cntFf  <= 5'h0;
         pendFf <= '0;
      end else if (take) begin
         cntFf  <= latOf(issue.op) - 5'h1;
         pendFf <= nowRes;
      end else if (cntFf != 5'h0) begin
         cntFf <= cntFf - 5'h1;
      end
   end

   // prefix literal, consumed by whatever instruction follows
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         immValidFf <= 1'b0;
         immHiFf    <= 16'h0;
      end else if (take) begin
         immValidFf <= (issue.op == OP_PREFIX);
         immHiFf    <= issue.literalField;
      end
   end

   // writeback, jump and exception request, all on the final cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wbValid  <= 1'b0;
         wbData   <= 32'h0;
         pcLoad   <= 1'b0;
         pcTarget <= 32'h0;
         excReq   <= 1'b0;
      end else begin
         wbValid <= fire && fin.wr;
         pcLoad  <= fire && fin.pcLd;
         excReq  <= fire && fin.exc;
         if (fire && fin.wr) wbData <= fin.data;
         if (fire && fin.pcLd) pcTarget <= fin.target;
      end
   end

   // bus write channel holding registers; address and data in either order
   logic              awHeldFf;
   logic              wHeldFf;
   logic [ADDR_W-1:0] awAddrFf;
   logic [31:0]       wDataFf;
   logic [3:0]        wStrbFf;
   logic              doWrite;
   logic [1:0]        bRespFf;
   logic              bValidFf;

   assign s_axi_awready = !awHeldFf;
   assign s_axi_wready  = !wHeldFf;
   assign doWrite       = awHeldFf && wHeldFf && !bValidFf;
   assign s_axi_bvalid  = bValidFf;
   assign s_axi_bresp   = bRespFf;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         awHeldFf <= 1'b0;
         wHeldFf  <= 1'b0;
         awAddrFf <= '0;
         wDataFf  <= 32'h0;
         wStrbFf  <= 4'h0;
         bValidFf <= 1'b0;
         bRespFf  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !awHeldFf) begin
            awHeldFf <= 1'b1;
            awAddrFf <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !wHeldFf) begin
            wHeldFf <= 1'b1;
            wDataFf <= s_axi_wdata;
            wStrbFf <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeldFf <= 1'b0;
            wHeldFf  <= 1'b0;
            bValidFf <= 1'b1;
            bRespFf  <= (awAddrFf[1:0] != 2'h0 || awAddrFf > ADDR_CTRL)
                        ? RESP_SLVERR : RESP_OKAY;
         end else if (bValidFf && s_axi_bready) begin
            bValidFf <= 1'b0;
         end
      end
   end

   logic wrLane0;  // only the low byte lane holds any field
   assign wrLane0 = doWrite && wStrbFf[0];

   // state and status registers; a hardware set wins over a software clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         breakActive <= 1'b0;
         floatStatus <= '0;
         causeCode   <= 5'h0;
         barrelEnFf  <= BARREL_EN_RST;
      end else begin
         if (wrLane0 && awAddrFf == ADDR_MSTATE)
            breakActive <= wDataFf[MS_BRK_BIT];
         if (fire && fin.pcLd) breakActive <= 1'b1;
         if (wrLane0 && awAddrFf == ADDR_FSTAT)
            floatStatus <= (floatStatus & ~wDataFf[4:0]) | fin.fl & {5{fire}};
         else if (fire)
            floatStatus <= floatStatus | fin.fl;
         if (wrLane0 && awAddrFf == ADDR_ESTAT) causeCode <= 5'h0;
         if (fire && fin.exc) causeCode <= CAUSE_FP;
         if (wrLane0 && awAddrFf == ADDR_CTRL) barrelEnFf <= wDataFf[CTRL_BSH_BIT];
      end
   end

   // read channel, one read outstanding
   logic        rValidFf;
   logic [31:0] rDataFf;
   logic [1:0]  rRespFf;

   assign s_axi_arready = !rValidFf;
   assign s_axi_rvalid  = rValidFf;
   assign s_axi_rdata   = rDataFf;
   assign s_axi_rresp   = rRespFf;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rValidFf <= 1'b0;
         rDataFf  <= 32'h0;
         rRespFf  <= RESP_OKAY;
      end else if (s_axi_arvalid && !rValidFf) begin
         rValidFf <= 1'b1;
         rRespFf  <= RESP_OKAY;
         rDataFf  <= 32'h0;
         case (s_axi_araddr)
            ADDR_MSTATE: rDataFf[MS_BRK_BIT] <= breakActive;
            ADDR_FSTAT:  rDataFf[4:0] <= floatStatus;
            ADDR_ESTAT:  rDataFf[4:0] <= causeCode;
            ADDR_CTRL:   rDataFf[CTRL_BSH_BIT] <= barrelEnFf;
            default:     rRespFf <= RESP_SLVERR;
         endcase
      end else if (rValidFf && s_axi_rready) begin
         rValidFf <= 1'b0;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_break_latency: assert property (
      take && issue.op == OP_BRK_REG |-> ##3 (pcLoad && wbValid))
      else $error("break did not complete in 3 cycles");
   a_break_flag: assert property (
      pcLoad |-> breakActive && wbValid)
      else $error("break jump without break flag");
   a_shift_latency: assert property (
      take && issue.op == OP_SHIFT_LIT && barrelEnFf |-> ##2 wbValid)
      else $error("shift did not complete in 2 cycles");
   a_cmp_equal_msb: assert property (
      take && issue.op == OP_CMP && issue.firstSrc == issue.secondSrc
      |=> wbValid && wbData == 32'h0)
      else $error("compare of equal operands not zero");
   a_fadd_latency: assert property (
      take && issue.op == OP_FADD |-> ##6 (wbValid || excReq))
      else $error("add did not complete in 6 cycles");
   a_fdiv_latency: assert property (
      take && issue.op == OP_FDIV |-> ##30 (wbValid || excReq))
      else $error("divide did not complete in 30 cycles");
   a_exc_nowrite: assert property (
      excReq |-> !wbValid && $stable(wbData))
      else $error("destination written on float exception");
   a_exc_cause: assert property (
      excReq |-> causeCode == CAUSE_FP && floatStatus != 5'h0)
      else $error("exception request without cause code");
endmodule : escf_exec

/* tb/escf_decode_model.sv */
`timescale 1ns/1ps
// decode stage and register file model: offers one instruction at a time
module escf_decode_model
   import escf_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  issueReady,
   output logic        issueValid,
   output escf_issue_s issue
);
   initial begin
      issueValid = 1'b0;
      issue      = '0;
   end
   // request held unchanged until the edge that sees ready high
   task automatic send(input escf_issue_s i);
      logic go;
      @(posedge clk);
      issueValid <= 1'b1;
      issue      <= i;
      do begin
         @(negedge clk);
         go = issueReady;
         @(posedge clk);
      end while (go !== 1'b1);
      issueValid <= 1'b0;
      issue      <= ~i;  // released operands show no stale value
   endtask : send
endmodule : escf_decode_model

/* tb/escf_exec_test.sv */
`timescale 1ns/1ps
module escf_exec_test;
   import escf_pkg::*;
   // one expected result: exception flag mask or data, with its latency
   typedef struct {logic exc; logic brk; logic [31:0] val; logic [31:0] tgt; int lat;} escf_note_s;
   escf_note_s notes[$];
   logic clk, rst_n, issueValid, issueReady, wbValid, pcLoad, excReq, breakActive;
   logic [31:0] wbData, pcTarget, lastWb, seed = 32'h1, wData, rData;
   escf_issue_s issue;
   escf_fflags_s floatStatus;
   logic [4:0] causeCode;
   logic [3:0] awAddr, arAddr;
   logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
   logic [1:0] bResp, rResp;
   int mismatches = 0, comparisons = 0, cyc = 0, takeCyc = 0;
   escf_exec u_escf_exec (.clk(clk), .rst_n(rst_n), .issueValid(issueValid),
      .issueReady(issueReady), .issue(issue), .wbValid(wbValid), .wbData(wbData),
      .pcLoad(pcLoad), .pcTarget(pcTarget), .excReq(excReq), .breakActive(breakActive),
      .floatStatus(floatStatus), .causeCode(causeCode), .s_axi_awaddr(awAddr),
      .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
      .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
   escf_decode_model u_escf_decode_model (.clk(clk), .issueReady(issueReady),
      .issueValid(issueValid), .issue(issue));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // cycle count doubles as the hang limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // m = {leftDir, signFillSel, noSignFlag}; lat 0 means no result expected
   task automatic op(input escf_op_e o, input logic [2:0] m, input logic [31:0] a, b,
      input logic [15:0] lit, input logic [31:0] v, input int lat);
      escf_issue_s i;
      escf_note_s n;
      i = '{o, m[2], m[1], m[0], a, b, lit, rnd()};
      n = '{o >= OP_FADD && v < 32'h20, o == OP_BRK_REG || o == OP_BRK_LIT, v, v, lat};
      if (n.brk) n.val = i.pc;
      if (lat > 0 && (o >= OP_FADD || n.brk || o == OP_CMP || o <= OP_SHIFT_LIT)) notes.push_back(n);
      u_escf_decode_model.send(i);
   endtask : op
   // monitor: pops the oldest note whenever a result or exception appears
   always @(negedge clk) begin : mon
      escf_note_s n;
      if (rst_n && (wbValid || excReq)) begin
         if (notes.size() == 0) check("spurious result", 32'(wbValid | excReq), 32'h0);
         else begin
            n = notes.pop_front();
            check("latency", 32'(cyc - takeCyc), 32'(n.lat));
            check("exception", 32'(excReq), 32'(n.exc));
            check("write", 32'(wbValid), 32'(!n.exc));
            if (n.exc) begin
               check("dest", wbData, lastWb);
               check("cause", 32'(causeCode), 32'(CAUSE_FP));
               check("flags", 32'(floatStatus & n.val[4:0]), n.val);
            end else begin
               check("data", wbData, n.val);
               lastWb = wbData;
               if (n.brk) check("target", pcTarget, n.tgt);
               if (n.brk) check("break", 32'({pcLoad, breakActive}), 32'h3);
            end
         end
      end
      if (issueValid && issueReady) takeCyc = cyc;
   end
   task automatic axiWr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] r;
      @(posedge clk);
      {awAddr, wData, awValid, wValid, bReady} <= {a, d, 3'h7};
      do begin
         @(negedge clk);
         {aw, w, b, r} = {awValid & awReady, wValid & wReady, bValid, bResp};
         @(posedge clk);
         if (aw) awValid <= 1'b0;
         if (w) wValid <= 1'b0;
         if (b) bReady <= 1'b0;
      end while (b !== 1'b1);
      check("bresp", 32'(r), 32'(er));
   endtask : axiWr
   task automatic axiRd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ar, rv;
      logic [33:0] r;
      @(posedge clk);
      {arAddr, arValid, rReady} <= {a, 2'h3};
      do begin
         @(negedge clk);
         {ar, rv, r} = {arValid & arReady, rValid, rResp, rData};
         @(posedge clk);
         if (ar) arValid <= 1'b0;
         if (rv) rReady <= 1'b0;
      end while (rv !== 1'b1);
      check("read", r[31:0], ed);
      check("rresp", 32'(r[33:32]), 32'(er));
   endtask : axiRd
   function automatic logic [31:0] cmpExp(input logic [31:0] a, b, input logic u);
      cmpExp = b + ~a + 32'h1;
      cmpExp[31] = u ? a > b : $signed(a) > $signed(b);
   endfunction : cmpExp
   function automatic logic [31:0] shExp(input logic [31:0] a, input logic [4:0] s, input logic [1:0] m);
      shExp = m[1] ? a << s : m[0] ? 32'($signed(a) >>> s) : a >> s;
   endfunction : shExp
   escf_op_e fo[14] = '{OP_FADD, OP_FRSUB, OP_FMUL, OP_FDIV, OP_FADD, OP_FMUL, OP_FADD,
      OP_FRSUB, OP_FMUL, OP_FDIV, OP_FDIV, OP_FMUL, OP_FMUL, OP_FADD};
   logic [31:0] fa[14] = '{32'h3f800000, 32'h3f800000, 32'h40000000, 32'h40000000,
      32'h7fc00000, 32'h00000001, 32'h7f800000, 32'h7f800000, 32'h00000000, 32'h0, 32'h0,
      32'h7f000000, 32'h00800000, 32'h7f800001};
   logic [31:0] fb[14] = '{32'h3f800000, 32'h40400000, 32'h40400000, 32'h40c00000,
      32'h3f800000, 32'h3f800000, 32'hff800000, 32'h7f800000, 32'h7f800000, 32'h0,
      32'h3f800000, 32'h7f000000, 32'h00800000, 32'h3f800000};
   logic [31:0] fv[14] = '{32'h40000000, 32'h40000000, 32'h40c00000, 32'h40400000,
      32'hffc00000, 32'h1, 32'h2, 32'h2, 32'h2, 32'h2, 32'h10, 32'h8, 32'h4, 32'h2};
   initial begin
      logic [31:0] a, x;
      logic [4:0] s;
      {rst_n, awAddr, wData, awValid, wValid, bReady, arAddr, arValid, rReady} = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      op(OP_CMP, 3'b000, 32'h1, 32'hffffffff, 16'h0, 32'hfffffffe, 1);
      op(OP_CMP, 3'b001, 32'h1, 32'hffffffff, 16'h0, 32'h7ffffffe, 1);
      op(OP_CMP, 3'b001, 32'h5, 32'h5, 16'h0, 32'h0, 1);
      for (int k = 0; k < 8; k++) begin
         a = rnd();
         x = rnd();
         op(OP_CMP, {2'b0, k[0]}, a, x, 16'h0, cmpExp(a, x, k[0]), 1);
      end
      for (int k = 0; k < 16; k++) begin
         a = rnd();
         x = rnd();
         s = k[3] ? {5{k[0]}} : x[4:0];
         op(k[2] ? OP_SHIFT_LIT : OP_SHIFT_REG, {k[1:0], 1'b0}, a,
            {x[31:5], k[2] ? ~s : s}, {x[15:5], s}, shExp(a, s, k[1:0]), 2);
      end
      op(OP_PREFIX, 3'b0, 32'h0, 32'h0, 16'h0007, 32'h0, 0);
      op(OP_SHIFT_LIT, 3'b100, 32'h1, 32'h0, 16'h0004, 32'h10, 2);
      op(OP_BRK_REG, 3'b0, 32'h0, 32'h1000, 16'h0, 32'h1000, 3);
      op(OP_BRK_LIT, 3'b0, 32'h0, 32'h0, 16'h8000, 32'hffff8000, 3);
      op(OP_PREFIX, 3'b0, 32'h0, 32'h0, 16'h1234, 32'h0, 0);
      op(OP_BRK_LIT, 3'b0, 32'h0, 32'h0, 16'h5678, 32'h12345678, 3);
      for (int k = 0; k < 14; k++)
         op(fo[k], 3'b0, fa[k], fb[k], 16'h0, fv[k], fo[k] == OP_FDIV ? 30 : 6);
      axiRd(ADDR_MSTATE, 32'h1, RESP_OKAY);
      axiWr(ADDR_FSTAT, 32'h1f, RESP_OKAY);
      axiRd(ADDR_FSTAT, 32'h0, RESP_OKAY);
      axiWr(4'h2, 32'h0, RESP_SLVERR);
      axiRd(4'h6, 32'h0, RESP_SLVERR);
      axiWr(ADDR_CTRL, 32'h0, RESP_OKAY);
      axiRd(ADDR_CTRL, 32'h0, RESP_OKAY);
      op(OP_SHIFT_REG, 3'b100, 32'h1, 32'h1, 16'h0, 32'h2, 0);
      repeat (4) @(posedge clk);
      axiWr(ADDR_CTRL, 32'h1, RESP_OKAY);
      repeat (40) @(posedge clk);
      check("pending", 32'(notes.size()), 32'h0);
      stop_test();
   end
endmodule : escf_exec_test
